// ---- rtl/load_prot_pkg.sv ----
// shared constants and types for the load protection latch
package load_prot_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int VALUE_W = 16;
    localparam int DELAY_W = 16;
    localparam int TEMP_W = 8;
    localparam int GRID_N = 5;
    localparam int TRIP_N = 2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MS_TIME_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned NS_PER_S = 1_000_000_000;
    localparam int unsigned SELFTEST_TIME_S = 5;
    localparam int unsigned SELFTEST_CYCLES_DEF = SELFTEST_TIME_S * (NS_PER_S / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // thresholds, indexes and reset values
    // ----------------------------------------------------------------
    localparam logic [TEMP_W-1:0] TEMP_TRIP_C = 8'h50;
    localparam logic [TEMP_W-1:0] TEMP_RESUME_C = 8'h4B;
    localparam int GRID_VOLT_HIGH_BIT = 0;
    localparam int GRID_VOLT_LOW_BIT = 1;
    localparam int GRID_FREQ_HIGH_BIT = 2;
    localparam int GRID_FREQ_LOW_BIT = 3;
    localparam int GRID_CURRENT_HIGH_BIT = 4;
    localparam int TRIP_CURRENT_IDX = 0;
    localparam int TRIP_POWER_IDX = 1;
    localparam logic FLAG_RST = 1'b0;
    localparam logic [VALUE_W-1:0] VALUE_RST = 16'h0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FAULT_NONE = 4'h0,
        FAULT_VOLT = 4'h1,
        FAULT_CURR = 4'h2,
        FAULT_POWER = 4'h3,
        FAULT_TEMP = 4'h4,
        FAULT_GRID_VOLT_HIGH = 4'h5,
        FAULT_GRID_VOLT_LOW = 4'h6,
        FAULT_GRID_FREQ_HIGH = 4'h7,
        FAULT_GRID_FREQ_LOW = 4'h8,
        FAULT_GRID_CURR = 4'h9
    } fault_code_t;

    typedef enum logic [1:0] {
        ST_SELFTEST = 2'b01,
        ST_READY = 2'b10
    } test_state_t;

endpackage

// ---- rtl/trip_timer_if.sv ----
// link between the supervisor and one delayed trip timer
`timescale 1ns/1ns
interface trip_timer_if #(
    parameter int VALUE_W = 16,
    parameter int DELAY_W = 16
);
    logic enable;
    logic tick;
    logic [VALUE_W-1:0] value;
    logic [VALUE_W-1:0] set_point;
    logic [DELAY_W-1:0] delay_ms;
    logic trip;

    modport owner (output enable, output tick, output value, output set_point, output delay_ms, input trip);
    modport timer (input enable, input tick, input value, input set_point, input delay_ms, output trip);
endinterface

// ---- rtl/trip_delay_timer.sv ----
// delayed trip timer for one measured quantity
`timescale 1ns/1ns
module trip_delay_timer
    import load_prot_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    trip_timer_if.timer tif
);
    localparam int DW = $bits(tif.delay_ms);

    logic [DW-1:0] elapsed_r;
    logic trip_r;
    logic over;

    assign over = tif.enable && (tif.value > tif.set_point);
    assign tif.trip = trip_r;

    // ----------------------------------------------------------------
    // elapsed milliseconds above the set point
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            elapsed_r <= '0;
        else if (!over)
            elapsed_r <= '0; // R17
        else if (tif.tick && (elapsed_r != '1))
            elapsed_r <= elapsed_r + 1'b1;
    end

    // ----------------------------------------------------------------
    // trip pulse once the delay is exceeded
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            trip_r <= FLAG_RST;
        else
            trip_r <= over && tif.tick && (elapsed_r >= tif.delay_ms); // R3 R6
    end

    a_restart_below: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R17
        !over |=> (elapsed_r == '0))
        else $error("delay timer did not restart below set point");

    a_trip_needs_over: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R3
        trip_r |-> $past(over) && $past(tif.tick) && ($past(elapsed_r) >= $past(tif.delay_ms)))
        else $error("trip without value above set point for the delay");
endmodule // trip_delay_timer

// ---- rtl/load_protection_latch.sv ----
// protection supervisor that trips and latches the load faults
// How it works
// R1 - an overvoltage detection turns the load off at once, sounds the buzzer and latches both voltage flags.
// R2 - Esc or the clear command removes the overvoltage indication and state.
// R3 - with overcurrent protection on, current above its set point past the delay trips off and latches flags.
// R4 - Esc or the clear command removes the overcurrent indication and state.
// R5 - the hardware power limit clamps the power command and never touches the on/off state.
// R6 - power above its set point past the delay trips off and latches the power and summary flags.
// R7 - Esc or the clear command removes the overpower indication and state.
// R8 - temperature above 80 degrees trips off and latches the temperature and summary flags.
// R9 - once temperature is back at 75 degrees the load goes to standby with the flag still latched; the code lets a load-on request switch it back on.
// R10 - Esc or the clear command removes the overtemperature indication and state.
// R11 - a grid voltage, current or frequency out of range turns the load off, sounds the buzzer and latches.
// R12 - each grid fault kind has its own fault code.
// R13 - during the first five seconds of self-test the load stays in standby and grid clears are ignored.
// R14 - a clear while a grid fault is still present restarts the self-test.
// R15 - grid faults other than overcurrent clear on Esc or the clear command once the grid has recovered.
// R16 - grid overcurrent ignores Esc and the clear command and is released only by reset.
// R17 - each delay timer restarts from zero whenever its value falls back to its set point.
`timescale 1ns/1ns
module load_protection_latch
    import load_prot_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int unsigned SELFTEST_CYCLES = SELFTEST_CYCLES_DEF
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic load_on_req_in,
    input wire logic load_off_req_in,
    input wire logic esc_key_in,
    input wire logic clear_cmd_in,
    input wire logic over_voltage_detect_in,
    input wire logic over_current_enable_in,
    input wire logic [VALUE_W-1:0] current_in,
    input wire logic [VALUE_W-1:0] current_set_in,
    input wire logic [DELAY_W-1:0] current_delay_ms_in,
    input wire logic [VALUE_W-1:0] power_in,
    input wire logic [VALUE_W-1:0] power_set_in,
    input wire logic [DELAY_W-1:0] power_delay_ms_in,
    input wire logic hw_power_limit_enable_in,
    input wire logic [VALUE_W-1:0] hw_power_limit_in,
    input wire logic [VALUE_W-1:0] power_demand_in,
    input wire logic [TEMP_W-1:0] temperature_in,
    input wire logic grid_volt_high_in,
    input wire logic grid_volt_low_in,
    input wire logic grid_freq_high_in,
    input wire logic grid_freq_low_in,
    input wire logic grid_current_high_in,
    output logic load_on_out,
    output logic buzzer_out,
    output logic standby_out,
    output logic [VALUE_W-1:0] power_cmd_out,
    output logic overvoltage_flag_out,
    output logic voltage_fault_flag_out,
    output logic overcurrent_flag_out,
    output logic overpower_flag_out,
    output logic overtemperature_flag_out,
    output logic protection_summary_flag_out,
    output logic [GRID_N-1:0] grid_fault_flags_out,
    output fault_code_t fault_code_out
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int TEST_W = $clog2(SELFTEST_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TEST_W-1:0] TEST_LAST = TEST_W'(SELFTEST_CYCLES - 1);

    generate
        if (TICK_CYCLES < 1 || SELFTEST_CYCLES < 1)
        begin : g_bad_param
            $error("tick and self-test counts must be at least one cycle");
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    test_state_t state_r;
    logic [TEST_W-1:0] test_cnt_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;
    logic load_on_r;
    logic buzzer_r;
    logic standby_r;
    logic [VALUE_W-1:0] power_cmd_r;
    logic ov_flag_r;
    logic vf_flag_r;
    logic oc_flag_r;
    logic op_flag_r;
    logic ot_flag_r;
    logic ps_flag_r;
    logic hot_active_r;
    logic [GRID_N-1:0] grid_latch_r;
    fault_code_t fault_code_r;

    // ----------------------------------------------------------------
    // combined events
    // ----------------------------------------------------------------
    logic clear_req;
    logic grid_clear_ok;
    logic [GRID_N-1:0] grid_raw;
    logic grid_raw_any;
    logic temp_hot;
    logic temp_cool;
    logic [TRIP_N-1:0] trip;
    logic trip_now;
    logic blocked;
    logic in_selftest;

    assign clear_req = esc_key_in || clear_cmd_in;
    assign in_selftest = (state_r == ST_SELFTEST);
    assign grid_clear_ok = clear_req && !in_selftest; // R13
    assign grid_raw[GRID_VOLT_HIGH_BIT] = grid_volt_high_in;
    assign grid_raw[GRID_VOLT_LOW_BIT] = grid_volt_low_in;
    assign grid_raw[GRID_FREQ_HIGH_BIT] = grid_freq_high_in;
    assign grid_raw[GRID_FREQ_LOW_BIT] = grid_freq_low_in;
    assign grid_raw[GRID_CURRENT_HIGH_BIT] = grid_current_high_in;
    assign grid_raw_any = |grid_raw;
    assign temp_hot = temperature_in > TEMP_TRIP_C;
    assign temp_cool = temperature_in <= TEMP_RESUME_C;
    assign trip_now = over_voltage_detect_in || (|trip) || temp_hot || grid_raw_any;
    assign blocked = in_selftest || hot_active_r || ov_flag_r || oc_flag_r || op_flag_r || (|grid_latch_r);

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else if (tick_cnt_r == TICK_LAST)
        begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // delayed trip timers for current and power
    // ----------------------------------------------------------------
    trip_timer_if #(.VALUE_W(VALUE_W), .DELAY_W(DELAY_W)) tif [TRIP_N] ();

    logic [VALUE_W-1:0] meas_a [TRIP_N];
    logic [VALUE_W-1:0] set_a [TRIP_N];
    logic [DELAY_W-1:0] delay_a [TRIP_N];
    logic en_a [TRIP_N];

    assign meas_a[TRIP_CURRENT_IDX] = current_in;
    assign set_a[TRIP_CURRENT_IDX] = current_set_in;
    assign delay_a[TRIP_CURRENT_IDX] = current_delay_ms_in;
    assign en_a[TRIP_CURRENT_IDX] = over_current_enable_in;
    assign meas_a[TRIP_POWER_IDX] = power_in;
    assign set_a[TRIP_POWER_IDX] = power_set_in;
    assign delay_a[TRIP_POWER_IDX] = power_delay_ms_in;
    assign en_a[TRIP_POWER_IDX] = 1'b1;

    generate
        for (genvar i = 0; i < TRIP_N; i++)
        begin : g_trip
            assign tif[i].enable = en_a[i];
            assign tif[i].tick = tick_r;
            assign tif[i].value = meas_a[i];
            assign tif[i].set_point = set_a[i];
            assign tif[i].delay_ms = delay_a[i];
            assign trip[i] = tif[i].trip;
            trip_delay_timer u_timer (
                .clk_in(clk_in),
                .reset_n_in(reset_n_in),
                .tif(tif[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // self-test sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_r <= ST_SELFTEST;
            test_cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_SELFTEST:
                begin
                    if (test_cnt_r == TEST_LAST) // R13
                    begin
                        state_r <= ST_READY;
                        test_cnt_r <= '0;
                    end
                    else
                        test_cnt_r <= test_cnt_r + 1'b1;
                end
                ST_READY:
                begin
                    if (clear_req && grid_raw_any) // R14
                    begin
                        state_r <= ST_SELFTEST;
                        test_cnt_r <= '0;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // load on/off switch
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            load_on_r <= 1'b0;
        else if (trip_now || load_off_req_in || blocked)
            load_on_r <= 1'b0; // R1 R3 R6 R8 R11 R13
        else if (load_on_req_in)
            load_on_r <= 1'b1;
    end

    // ----------------------------------------------------------------
    // voltage, current and power flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ov_flag_r <= FLAG_RST;
            vf_flag_r <= FLAG_RST;
        end
        else if (over_voltage_detect_in)
        begin
            ov_flag_r <= 1'b1; // R1
            vf_flag_r <= 1'b1; // R1
        end
        else if (clear_req)
        begin
            ov_flag_r <= 1'b0; // R2
            vf_flag_r <= 1'b0; // R2
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            oc_flag_r <= FLAG_RST;
        else if (trip[TRIP_CURRENT_IDX])
            oc_flag_r <= 1'b1; // R3
        else if (clear_req)
            oc_flag_r <= 1'b0; // R4
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            op_flag_r <= FLAG_RST;
        else if (trip[TRIP_POWER_IDX])
            op_flag_r <= 1'b1; // R6
        else if (clear_req)
            op_flag_r <= 1'b0; // R7
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            ps_flag_r <= FLAG_RST;
        else if ((|trip) || temp_hot)
            ps_flag_r <= 1'b1; // R3 R6 R8
        else if (clear_req)
            ps_flag_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // temperature protection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            hot_active_r <= 1'b0;
        else if (temp_hot)
            hot_active_r <= 1'b1; // R8
        else if (temp_cool)
            hot_active_r <= 1'b0; // R9
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            ot_flag_r <= FLAG_RST;
        else if (temp_hot)
            ot_flag_r <= 1'b1; // R8
        else if (clear_req)
            ot_flag_r <= 1'b0; // R10
    end

    // ----------------------------------------------------------------
    // grid fault latches
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < GRID_N; g++)
        begin : g_grid
            always_ff @(posedge clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                    grid_latch_r[g] <= FLAG_RST;
                else if (grid_raw[g])
                    grid_latch_r[g] <= 1'b1; // R11
                else if (grid_clear_ok && !grid_raw_any && (g != GRID_CURRENT_HIGH_BIT))
                    grid_latch_r[g] <= 1'b0; // R15 R16
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // buzzer, standby, power clamp and fault code
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            buzzer_r <= 1'b0;
            standby_r <= 1'b1;
            power_cmd_r <= VALUE_RST;
        end
        else
        begin
            buzzer_r <= over_voltage_detect_in || ov_flag_r || grid_raw_any || (|grid_latch_r); // R1 R11
            standby_r <= in_selftest || !load_on_r; // R9 R13
            if (hw_power_limit_enable_in && (power_demand_in > hw_power_limit_in))
                power_cmd_r <= hw_power_limit_in; // R5
            else
                power_cmd_r <= power_demand_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            fault_code_r <= FAULT_NONE;
        else if (grid_latch_r[GRID_CURRENT_HIGH_BIT])
            fault_code_r <= FAULT_GRID_CURR; // R12
        else if (grid_latch_r[GRID_VOLT_HIGH_BIT])
            fault_code_r <= FAULT_GRID_VOLT_HIGH;
        else if (grid_latch_r[GRID_VOLT_LOW_BIT])
            fault_code_r <= FAULT_GRID_VOLT_LOW;
        else if (grid_latch_r[GRID_FREQ_HIGH_BIT])
            fault_code_r <= FAULT_GRID_FREQ_HIGH;
        else if (grid_latch_r[GRID_FREQ_LOW_BIT])
            fault_code_r <= FAULT_GRID_FREQ_LOW;
        else if (ov_flag_r)
            fault_code_r <= FAULT_VOLT;
        else if (ot_flag_r)
            fault_code_r <= FAULT_TEMP;
        else if (oc_flag_r)
            fault_code_r <= FAULT_CURR;
        else if (op_flag_r)
            fault_code_r <= FAULT_POWER;
        else
            fault_code_r <= FAULT_NONE;
    end

    assign load_on_out = load_on_r;
    assign buzzer_out = buzzer_r;
    assign standby_out = standby_r;
    assign power_cmd_out = power_cmd_r;
    assign overvoltage_flag_out = ov_flag_r;
    assign voltage_fault_flag_out = vf_flag_r;
    assign overcurrent_flag_out = oc_flag_r;
    assign overpower_flag_out = op_flag_r;
    assign overtemperature_flag_out = ot_flag_r;
    assign protection_summary_flag_out = ps_flag_r;
    assign grid_fault_flags_out = grid_latch_r;
    assign fault_code_out = fault_code_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_volt_trip_off: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R1
        over_voltage_detect_in |=> !load_on_r && ov_flag_r && vf_flag_r ##1 buzzer_r)
        else $error("overvoltage did not switch off and latch");

    a_volt_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R2
        ov_flag_r && clear_req && !over_voltage_detect_in |=> !ov_flag_r && !vf_flag_r)
        else $error("overvoltage flags not cleared");

    a_curr_trip: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R3
        trip[TRIP_CURRENT_IDX] |=> !load_on_r && oc_flag_r && ps_flag_r ##1 fault_code_r != FAULT_NONE)
        else $error("current trip did not latch");

    a_power_clamp: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
        hw_power_limit_enable_in |=> power_cmd_r <= $past(hw_power_limit_in))
        else $error("power command above hardware limit");

    a_temp_resume: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R9
        hot_active_r && temp_cool && ot_flag_r && !clear_req |=> !hot_active_r && ot_flag_r)
        else $error("temperature resume wrong");

    a_grid_hold_test: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R13
        in_selftest && (|grid_latch_r) |=> (|grid_latch_r))
        else $error("grid fault cleared during self-test");

    a_grid_retest: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R14
        !in_selftest && clear_req && grid_raw_any |=> in_selftest && test_cnt_r == '0)
        else $error("self-test not restarted");

    a_grid_curr_keep: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R16
        grid_latch_r[GRID_CURRENT_HIGH_BIT] |=> grid_latch_r[GRID_CURRENT_HIGH_BIT] ##1 !load_on_r)
        else $error("grid overcurrent released without reset");

    a_grid_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R15
        grid_latch_r[GRID_VOLT_LOW_BIT] && grid_clear_ok && !grid_raw_any |=> !grid_latch_r[GRID_VOLT_LOW_BIT])
        else $error("recovered grid fault not cleared");
endmodule // load_protection_latch

// ---- tb/host_model.sv ----
// remote host model that issues fault clear commands
`timescale 1ns/1ns
module host_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_in,
    output logic clear_out
);
    always_ff @(posedge clk_in or negedge reset_n_in)
        if (!reset_n_in) clear_out <= 1'b0;
        else clear_out <= req_in & ~clear_out;
endmodule // host_model

// ---- tb/testbench.sv ----
// self-checking bench for the load protection latch
`timescale 1ns/1ns
module testbench;
    import load_prot_pkg::*;
    logic clk_in = 1'b0, reset_n_in = 1'b0, esc = 1'b0, hreq = 1'b0, ov = 1'b0, hwe = 1'b1, hclr;
    logic lo, bz, sb, fov, fvf, foc, fop, fot, fps;
    logic [15:0] cur = 16'h0000, cs = 16'h0100, cd = 16'h0003, hl = 16'h0050, dm = 16'h0080, pcmd;
    logic [15:0] pw = 16'h0000;
    logic [7:0] tmp = 8'h19;
    logic [4:0] grid = 5'h00, gf;
    fault_code_t fc;
    int miscompares = 0, n_tests = 0;
    always #20 clk_in = ~clk_in;
    host_model host (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(hreq), .clear_out(hclr));
    load_protection_latch #(.TICK_CYCLES(4), .SELFTEST_CYCLES(20)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .load_on_req_in(1'b1), .load_off_req_in(1'b0), .esc_key_in(esc), .clear_cmd_in(hclr),
        .over_voltage_detect_in(ov), .over_current_enable_in(1'b1), .current_in(cur), .current_set_in(cs),
        .current_delay_ms_in(cd), .power_in(pw), .power_set_in(cs), .power_delay_ms_in(cd),
        .hw_power_limit_enable_in(hwe), .hw_power_limit_in(hl), .power_demand_in(dm), .temperature_in(tmp),
        .grid_volt_high_in(grid[0]), .grid_volt_low_in(grid[1]), .grid_freq_high_in(grid[2]),
        .grid_freq_low_in(grid[3]), .grid_current_high_in(grid[4]), .load_on_out(lo), .buzzer_out(bz),
        .standby_out(sb), .power_cmd_out(pcmd), .overvoltage_flag_out(fov), .voltage_fault_flag_out(fvf),
        .overcurrent_flag_out(foc), .overpower_flag_out(fop), .overtemperature_flag_out(fot),
        .protection_summary_flag_out(fps), .grid_fault_flags_out(gf), .fault_code_out(fc));
    task w(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        miscompares += int'(g !== e);
        if (g !== e) $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    endtask
    task clr(input bit h);
        {hreq, esc} <= {h, !h};
        w(1);
        {hreq, esc} <= 2'b00;
        w(3);
    endtask
    task print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_ov;
        w(3);
        chk({lo, sb}, 2'b01);
        w(25);
        chk({lo, sb, pcmd}, 18'h2_0050);
        {ov, hwe} <= 2'b10;
        w(1);
        ov <= 1'b0;
        w(2);
        chk({lo, fov, fvf, bz, fc, pcmd}, 24'h71_0080);
        clr(0);
        chk({lo, fov, fvf, bz, fc}, 8'h80);
    endtask
    task t_trip;
        cur <= 16'h0101;
        w(30);
        chk({lo, foc, fps, fc}, 7'h32);
        cur <= 16'h0000;
        clr(1);
        chk({lo, foc, fps, fc}, 7'h40);
        tmp <= 8'h51;
        w(3);
        chk({lo, fot, fps, fc}, 7'h34);
        tmp <= 8'h4B;
        w(4);
        chk({lo, fot}, 2'b11);
        clr(0);
        chk({fot, fc}, 5'h00);
        pw <= 16'h0101;
        w(30);
        chk({lo, fop, fps, fc}, 7'h33);
        pw <= 16'h0000;
        clr(1);
        chk({lo, fop, fps, fc}, 7'h40);
    endtask
    task t_grid;
        for (int i = 0; i < 4; i++)
        begin
            grid <= 5'h01 << i;
            w(1);
            grid <= 5'h00;
            w(2);
            chk({lo, bz, gf, fc}, {2'b01, 5'h01 << i, 4'h5 + i[3:0]});
            clr(i[0]);
        end
        grid <= 5'h12;
        w(3);
        clr(1);
        chk({sb, gf}, 6'h32);
        grid <= 5'h00;
        clr(0);
        chk({lo, gf}, 6'h12);
        w(25);
        clr(0);
        chk({gf, fc}, 9'h109);
        reset_n_in <= 1'b0;
        w(2);
        reset_n_in <= 1'b1;
        chk({gf, sb}, 6'h01);
    endtask
    initial
    begin
        w(16);
        reset_n_in <= 1'b1;
        t_ov;
        t_trip;
        t_grid;
        print_verdict;
    end
    initial
    begin
        w(3000);
        miscompares++;
        print_verdict;
    end
endmodule // testbench
